// ---- cmp_bank_if.sv ----
// Purpose: Single access port shared by the message engine and status port to reach the register bank.
// Assumes: One access per cycle; read data is combinational.
// Notes: hit is low for register numbers the bank does not hold.
`timescale 1ns/100ps
interface cmp_bank_if;
	logic we;
	logic [15:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic hit;
	modport master (output we, output addr, output wdata, input rdata,
		input hit);
	modport bank (input we, input addr, input wdata, output rdata,
		output hit);
endinterface

// ---- cmp_chan_model.sv ----
// Purpose: Requesting channel-end that sends tokens and takes replies.
// Assumes: A token is held until the port takes it.
// Notes: slow drops trdy_o every other cycle, so each reply token after the first waits one cycle.
`timescale 1ns/100ps
module cmp_chan_model (
	input wire logic clk_i,
	input wire logic rdy_i,
	output logic vld_o,
	output logic ctl_o,
	output logic [7:0] dat_o,
	input wire logic tvld_i,
	input wire logic tctl_i,
	input wire logic [7:0] tdat_i,
	input wire logic [23:0] tdest_i,
	output logic trdy_o
);
	logic slow = 1'b0;
	logic [32:0] got[$];
	logic [31:0] dest = 32'h0;
	int stalls = 0;
	initial {vld_o, ctl_o, dat_o, trdy_o} = 11'h000;
	task automatic send(logic c, logic [7:0] d);
		int k;
		@(posedge clk_i);
		{vld_o, ctl_o, dat_o} <= {1'b1, c, d};
		@(negedge clk_i);
		for (k = 0; k < 300 && !rdy_i; k++) @(negedge clk_i);
		if (k == 300) stalls++;
		@(posedge clk_i);
		{vld_o, ctl_o, dat_o} <= {1'b0, ~c, ~d};
	endtask
	// Forms the channel-end destination for one register space.
	task automatic aim(logic [1:0] space, logic [15:0] node, logic [7:0] pp);
		if (space == 2'h0) dest = {node, cmp_pkg::TILE_EP_CODE};
		else if (space == 2'h1) dest = {node, cmp_pkg::NODE_EP_CODE};
		else dest = {node, pp, cmp_pkg::PERIPH_EP_CODE};
	endtask
	always @(posedge clk_i) begin
		if (tvld_i && trdy_o) got.push_back({tdest_i, tctl_i, tdat_i});
		trdy_o <= slow ? ~trdy_o : 1'b1;
	end
endmodule // cmp_chan_model

// ---- cmp_monitor.sv ----
// Purpose: Port checker for the message port.
// Assumes: Reset is asynchronous and active low.
// Notes: Bound to every port instance below.
`timescale 1ns/100ps
module cmp_monitor #(
	parameter int NREG = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rx_valid_i,
	input wire logic rx_ctrl_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_ready_o,
	input wire logic tx_valid_o,
	input wire logic tx_ctrl_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic ps_req_i,
	input wire logic [15:0] ps_resid_i,
	input wire logic ps_ack_o,
	input wire logic ps_err_o
);
	logic [15:0] id_q;
	logic rx_end, tx_end;
	always_ff @(posedge clk_i) id_q <= ps_resid_i;
	assign rx_end = rx_valid_i && rx_ready_o && rx_ctrl_i && rx_data_i == 8'h01;
	assign tx_end = tx_valid_o && tx_ready_i && tx_ctrl_o && tx_data_o == 8'h01;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable({tx_ctrl_o, tx_data_o})) else $error("tx moved");
	first_tok_a: assert property ($rose(tx_valid_o) |-> tx_ctrl_o &&
		(tx_data_o == 8'h03 || tx_data_o == 8'h04)) else $error("first");
	reply_lat_a: assert property (rx_end ##1 !rx_ready_o |->
		##1 tx_valid_o) else $error("reply late");
	rx_busy_a: assert property (tx_valid_o |-> !rx_ready_o)
		else $error("rx busy");
	reply_end_a: assert property (tx_end |=> !tx_valid_o && rx_ready_o)
		else $error("reply end");
	ack_pulse_a: assert property (ps_ack_o |=> !ps_ack_o) else $error("ack");
	ack_due_a: assert property (ps_req_i && !ps_ack_o |-> ##[1:2] ps_ack_o)
		else $error("ack late");
	status_err_a: assert property (ps_ack_o |-> ps_err_o ==
		(id_q[7:0] != 8'h0C || id_q[15:8] >= NREG)) else $error("err");
endmodule // cmp_monitor
bind cmp_msg_port cmp_monitor #(.NREG(NREG)) u_mon (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.rx_valid_i(rx_valid_i),
	.rx_ctrl_i(rx_ctrl_i),
	.rx_data_i(rx_data_i),
	.rx_ready_o(rx_ready_o),
	.tx_valid_o(tx_valid_o),
	.tx_ctrl_o(tx_ctrl_o),
	.tx_data_o(tx_data_o),
	.tx_ready_i(tx_ready_i),
	.ps_req_i(ps_req_i),
	.ps_resid_i(ps_resid_i),
	.ps_ack_o(ps_ack_o),
	.ps_err_o(ps_err_o)
);

// ---- cmp_msg_port.sv ----
// Purpose: Token-framed configuration endpoint with a status word port.
// Assumes: Token streams use valid/ready; a status request holds until ack.
// Notes: Data bytes of multi-byte fields travel most significant first.
//
// Overview of operation
// R1: Status resource id is register number shifted left eight, ORed with 0x0C.
// R2: Status port reads or writes one whole 32-bit word by resource id.
// R3: Tile access targets destination tile id over endpoint code C20C.
// R4: Node access targets node id in upper 16 bits over code C30C.
// R5: Peripheral access: node id, peripheral id in 15:8, 0x02 low byte.
// R6: Write: token 192, 24-bit return id, 16-bit register, 32-bit data, token 1.
// R7: Write reply is tokens 3,1 on success, tokens 4,1 on failure.
// R8: Read: token 193, 24-bit return id, 16-bit register, token 1.
// R9: Read reply is token 3, 32 data bits, token 1; failure 4,1.
// R10: Peripheral read: token 37, return id, 8-bit register, size, token 1.
// R11: Replies go to the return id; act only after closing token 1.
// R12: Unknown register or unknown opening token gives the failure reply.
`timescale 1ns/100ps
module cmp_msg_port #(
	parameter int NREG = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rx_valid_i,
	input wire logic rx_ctrl_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	output logic tx_valid_o,
	output logic tx_ctrl_o,
	output logic [7:0] tx_data_o,
	output logic [23:0] tx_dest_o,
	input wire logic tx_ready_i,
	input wire logic ps_req_i,
	input wire logic ps_wr_i,
	input wire logic [15:0] ps_resid_i,
	input wire logic [31:0] ps_wdata_i,
	output logic ps_ack_o,
	output logic ps_err_o,
	output logic [31:0] ps_rdata_o
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_RET, ST_REG, ST_SIZE, ST_DATA, ST_END, ST_DRAIN,
		ST_EXEC, ST_HDR, ST_BODY, ST_TAIL
	} cmp_state_e;

	cmp_bank_if bank_bus ();

	cmp_reg_bank #(.NREG(NREG)) u_bank (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.bus(bank_bus)
	);

	cmp_state_e state, next_state;
	cmp_pkg::cmp_op_e op, next_op;
	logic bad, next_bad;
	logic [1:0] cnt, next_cnt;
	logic [23:0] ret_id, next_ret_id;
	logic [15:0] regnum, next_regnum;
	logic [7:0] size, next_size;
	logic [31:0] word, next_word;
	logic [2:0] left, next_left;
	logic next_rx_ready, next_tx_valid, next_tx_ctrl;
	logic [7:0] next_tx_data;
	logic [23:0] next_tx_dest;
	logic next_ps_ack, next_ps_err;
	logic [31:0] next_ps_rdata;
	logic rx_take, tx_done, ctrl_end, ps_sel, ok;

	always_comb begin
		rx_take = rx_valid_i && rx_ready_o;
		tx_done = tx_valid_o && tx_ready_i;
		ctrl_end = rx_ctrl_i && rx_data_i == cmp_pkg::TOK_END;
		ps_sel = state != ST_EXEC && ps_req_i && !ps_ack_o;
		bank_bus.we = 1'b0;
		bank_bus.addr = regnum;
		bank_bus.wdata = word;
		ok = 1'b0;
		if (state == ST_EXEC) begin
			ok = !bad && bank_bus.hit; // R12
			if (op == cmp_pkg::OP_PREAD) begin
				ok = ok && size != 8'h0 && size <= 8'(cmp_pkg::WORD_BYTES);
			end
			bank_bus.we = ok && op == cmp_pkg::OP_WRITE;
		end else if (ps_sel) begin
			bank_bus.addr = 16'(ps_resid_i >> cmp_pkg::PS_SHIFT); // R1
			bank_bus.wdata = ps_wdata_i;
			bank_bus.we = ps_wr_i && ps_resid_i[7:0] == cmp_pkg::PS_RES_TYPE;
		end
	end

	always_comb begin
		next_ps_ack = ps_sel;
		next_ps_err = ps_err_o;
		next_ps_rdata = ps_rdata_o;
		if (ps_sel) begin
			next_ps_err = ps_resid_i[7:0] != cmp_pkg::PS_RES_TYPE ||
				!bank_bus.hit; // R2
			next_ps_rdata = bank_bus.rdata; // R2
		end
	end

	always_comb begin
		next_state = state;
		next_op = op;
		next_bad = bad;
		next_cnt = cnt;
		next_ret_id = ret_id;
		next_regnum = regnum;
		next_size = size;
		next_word = word;
		next_left = left;
		next_tx_valid = tx_valid_o;
		next_tx_ctrl = tx_ctrl_o;
		next_tx_data = tx_data_o;
		next_tx_dest = tx_dest_o;
		unique case (state)
			ST_IDLE: begin
				if (rx_take && rx_ctrl_i && !ctrl_end) begin
					next_bad = 1'b0;
					next_cnt = 2'h0;
					next_ret_id = 24'h0;
					next_regnum = 16'h0;
					next_size = 8'h0;
					next_state = ST_RET;
					if (rx_data_i == cmp_pkg::TOK_WRITE) begin
						next_op = cmp_pkg::OP_WRITE; // R6
					end else if (rx_data_i == cmp_pkg::TOK_READ) begin
						next_op = cmp_pkg::OP_READ; // R8
					end else if (rx_data_i == cmp_pkg::TOK_PREAD) begin
						next_op = cmp_pkg::OP_PREAD; // R10
					end else begin
						next_bad = 1'b1; // R12
						next_state = ST_DRAIN;
					end
				end
			end
			ST_RET, ST_REG, ST_SIZE, ST_DATA: begin
				if (rx_take && rx_ctrl_i) begin
					next_bad = 1'b1;
					next_state = ctrl_end ? ST_EXEC : ST_DRAIN;
				end else if (rx_take) begin
					next_cnt = cnt + 2'h1;
					if (state == ST_RET) begin
						next_ret_id = {ret_id[15:0], rx_data_i}; // R6
						if (cnt == cmp_pkg::RET_BYTES_M1) begin
							next_cnt = 2'h0;
							next_state = ST_REG;
						end
					end else if (state == ST_REG) begin
						next_regnum = {regnum[7:0], rx_data_i};
						if (op == cmp_pkg::OP_PREAD) begin
							next_cnt = 2'h0;
							next_state = ST_SIZE; // R10
						end else if (cnt == cmp_pkg::REG_BYTES_M1) begin
							next_cnt = 2'h0;
							next_state = op == cmp_pkg::OP_WRITE ?
								ST_DATA : ST_END; // R6 R8
						end
					end else if (state == ST_SIZE) begin
						next_size = rx_data_i;
						next_state = ST_END;
					end else begin
						next_word = {word[23:0], rx_data_i};
						if (cnt == cmp_pkg::DATA_BYTES_M1) begin
							next_state = ST_END;
						end
					end
				end
			end
			ST_END: begin
				if (rx_take) begin
					next_bad = !ctrl_end;
					next_state = ctrl_end ? ST_EXEC : ST_DRAIN; // R11
				end
			end
			ST_DRAIN: begin
				if (rx_take && ctrl_end) begin
					next_state = ST_EXEC; // R11
				end
			end
			ST_EXEC: begin
				next_tx_valid = 1'b1;
				next_tx_ctrl = 1'b1;
				next_tx_dest = ret_id; // R11
				next_tx_data = ok ? cmp_pkg::TOK_ACK : cmp_pkg::TOK_NACK; // R7
				next_left = 3'h0;
				next_word = bank_bus.rdata;
				if (ok && op == cmp_pkg::OP_READ) begin
					next_left = cmp_pkg::WORD_BYTES; // R9
				end else if (ok && op == cmp_pkg::OP_PREAD) begin
					next_left = size[2:0]; // R10
					next_word = bank_bus.rdata <<
						{3'(cmp_pkg::WORD_BYTES - size[2:0]), 3'h0};
				end
				next_state = ST_HDR;
			end
			ST_HDR, ST_BODY: begin
				if (tx_done) begin
					if (left != 3'h0) begin
						next_tx_ctrl = 1'b0;
						next_tx_data = word[31:24]; // R9
						next_word = {word[23:0], 8'h0};
						next_left = left - 3'h1;
						next_state = ST_BODY;
					end else begin
						next_tx_ctrl = 1'b1;
						next_tx_data = cmp_pkg::TOK_END; // R7 R9
						next_state = ST_TAIL;
					end
				end
			end
			ST_TAIL: begin
				if (tx_done) begin
					next_tx_valid = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_rx_ready = next_state inside {ST_IDLE, ST_RET, ST_REG, ST_SIZE,
			ST_DATA, ST_END, ST_DRAIN};
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			op <= cmp_pkg::OP_WRITE;
			bad <= 1'b0;
			cnt <= 2'h0;
			ret_id <= 24'h0;
			regnum <= 16'h0;
			size <= 8'h0;
			word <= 32'h0;
			left <= 3'h0;
			rx_ready_o <= 1'b1;
			tx_valid_o <= 1'b0;
			tx_ctrl_o <= 1'b0;
			tx_data_o <= 8'h0;
			tx_dest_o <= 24'h0;
			ps_ack_o <= 1'b0;
			ps_err_o <= 1'b0;
			ps_rdata_o <= 32'h0;
		end else begin
			state <= next_state;
			op <= next_op;
			bad <= next_bad;
			cnt <= next_cnt;
			ret_id <= next_ret_id;
			regnum <= next_regnum;
			size <= next_size;
			word <= next_word;
			left <= next_left;
			rx_ready_o <= next_rx_ready;
			tx_valid_o <= next_tx_valid;
			tx_ctrl_o <= next_tx_ctrl;
			tx_data_o <= next_tx_data;
			tx_dest_o <= next_tx_dest;
			ps_ack_o <= next_ps_ack;
			ps_err_o <= next_ps_err;
			ps_rdata_o <= next_ps_rdata;
		end
	end
endmodule // cmp_msg_port

// ---- cmp_pkg.sv ----
// Purpose: Shared constants for the configuration message port.
// Assumes: Interconnect tokens are eight bits with a control flag.
// Notes: Values are the token codes carried on the link, plus endpoint codes, field widths and byte counts.
package cmp_pkg;
	localparam int TOK_W = 8;
	localparam int RET_W = 24;
	localparam int REGNUM_W = 16;
	localparam int WORD_W = 32;
	localparam logic [7:0] TOK_WRITE = 8'hC0;
	localparam logic [7:0] TOK_READ = 8'hC1;
	localparam logic [7:0] TOK_PREAD = 8'h25;
	localparam logic [7:0] TOK_ACK = 8'h03;
	localparam logic [7:0] TOK_NACK = 8'h04;
	localparam logic [7:0] TOK_END = 8'h01;
	localparam logic [7:0] PS_RES_TYPE = 8'h0C;
	localparam int PS_SHIFT = 8;
	localparam logic [15:0] TILE_EP_CODE = 16'hC20C;
	localparam logic [15:0] NODE_EP_CODE = 16'hC30C;
	localparam logic [7:0] PERIPH_EP_CODE = 8'h02;
	localparam logic [1:0] RET_BYTES_M1 = 2'h2;
	localparam logic [1:0] REG_BYTES_M1 = 2'h1;
	localparam logic [1:0] DATA_BYTES_M1 = 2'h3;
	localparam logic [2:0] WORD_BYTES = 3'h4;
	typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_PREAD} cmp_op_e;
endpackage

// ---- cmp_reg_bank.sv ----
// Purpose: Array of configuration words behind the message port.
// Assumes: Writes land on the clock edge when we is high and hit.
// Notes: Register numbers at or above NREG miss.
`timescale 1ns/100ps
module cmp_reg_bank #(
	parameter int NREG = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	cmp_bank_if.bank bus
);
	logic [31:0] mem [NREG];

	always_comb begin
		bus.hit = bus.addr < 16'(NREG);
		bus.rdata = bus.hit ? mem[bus.addr[$clog2(NREG)-1:0]] : 32'h0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < NREG; i++) begin
				mem[i] <= 32'h0;
			end
		end else if (bus.we && bus.hit) begin
			mem[bus.addr[$clog2(NREG)-1:0]] <= bus.wdata;
		end
	end
endmodule // cmp_reg_bank

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the message port.
// Assumes: Clock of 100 MHz.
// Notes: Expected tokens are built here.
`timescale 1ns/100ps
module tb_top;
	logic clk_i = 1'b0;
	logic rst_n_i, rx_valid_i, rx_ctrl_i, rx_ready_o, tx_valid_o, tx_ctrl_o;
	logic tx_ready_i, ps_req_i, ps_wr_i, ps_ack_o, ps_err_o;
	logic [7:0] rx_data_i, tx_data_o;
	logic [23:0] tx_dest_o;
	logic [15:0] ps_resid_i;
	logic [31:0] ps_wdata_i, ps_rdata_o;
	localparam logic [23:0] RET = 24'h12AB34;
	int err_total = 0, n_checks = 0;
	cmp_msg_port #(.NREG(16)) DUT (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rx_valid_i(rx_valid_i),
		.rx_ctrl_i(rx_ctrl_i),
		.rx_data_i(rx_data_i),
		.rx_ready_o(rx_ready_o),
		.tx_valid_o(tx_valid_o),
		.tx_ctrl_o(tx_ctrl_o),
		.tx_data_o(tx_data_o),
		.tx_dest_o(tx_dest_o),
		.tx_ready_i(tx_ready_i),
		.ps_req_i(ps_req_i),
		.ps_wr_i(ps_wr_i),
		.ps_resid_i(ps_resid_i),
		.ps_wdata_i(ps_wdata_i),
		.ps_ack_o(ps_ack_o),
		.ps_err_o(ps_err_o),
		.ps_rdata_o(ps_rdata_o)
	);
	cmp_chan_model m (.clk_i(clk_i), .rdy_i(rx_ready_o), .vld_o(rx_valid_i),
		.ctl_o(rx_ctrl_i), .dat_o(rx_data_i), .tvld_i(tx_valid_o),
		.tctl_i(tx_ctrl_o), .tdat_i(tx_data_o), .tdest_i(tx_dest_o),
		.trdy_o(tx_ready_i));
	initial forever #5 clk_i = ~clk_i;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string n, logic [32:0] e, logic [32:0] s);
		n_checks++;
		err_total += (s !== e);
		if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
	endtask
	task automatic rq(logic [7:0] op, logic [15:0] rg, logic wr,
		logic [31:0] w);
		int k;
		logic [71:0] h;
		h = {RET, rg, w};
		m.send(1'b1, op);
		for (k = 8; k > (wr ? -1 : 3); k--) m.send(1'b0, h[8*k+:8]);
		m.send(1'b1, 8'h01);
	endtask
	task automatic rp(logic [23:0] d, logic ok, int nb, logic [31:0] w);
		int k;
		for (k = 0; k < 300 && m.got.size() < nb + 2; k++) @(negedge clk_i);
		chk("reply count", 33'(nb + 2), 33'(m.got.size()));
		chk("first token", {d, ok ? 9'h103 : 9'h104}, m.got[0]);
		for (k = 0; k < nb; k++)
			chk("data", {d, 1'b0, w[8*(nb-1-k)+:8]}, m.got[k + 1]);
		chk("last token", {d, 9'h101}, m.got[nb + 1]);
		m.got.delete();
	endtask
	task automatic ps(logic wr, logic [15:0] id, logic [31:0] w, logic er,
		logic [31:0] rd);
		int k;
		@(posedge clk_i);
		{ps_req_i, ps_wr_i, ps_resid_i, ps_wdata_i} <= {1'b1, wr, id, w};
		for (k = 0; k < 9 && ps_ack_o !== 1'b1; k++) @(negedge clk_i);
		chk("status ack", 33'h1, {32'h0, ps_ack_o});
		chk("status err", {32'h0, er}, {32'h0, ps_err_o});
		if (!wr) chk("status data", {1'b0, rd}, {1'b0, ps_rdata_o});
		@(posedge clk_i);
		ps_req_i <= 1'b0;
	endtask
	task automatic t_msg();
		m.slow = 1'b1;
		m.aim(2'h0, 16'h0001, 8'h00);
		chk("tile dest", {1'b0, 32'h0001C20C}, {1'b0, m.dest});
		rq(8'hC0, 16'h0005, 1'b1, 32'hA5C30F1E);
		rp(RET, 1'b1, 0, 32'h0);
		rq(8'hC1, 16'h0005, 1'b0, 32'h0);
		rp(RET, 1'b1, 4, 32'hA5C30F1E);
		m.slow = 1'b0;
		m.aim(2'h1, 16'h0002, 8'h00);
		chk("node dest", {1'b0, 32'h0002C30C}, {1'b0, m.dest});
		rq(8'hC1, 16'h0010, 1'b0, 32'h0);
		rp(RET, 1'b0, 0, 32'h0);
		rq(8'h55, 16'h0001, 1'b0, 32'h0);
		rp(24'h000000, 1'b0, 0, 32'h0);
		m.send(1'b1, 8'hC0);
		m.send(1'b0, 8'h12);
		m.send(1'b1, 8'h01);
		rp(24'h000012, 1'b0, 0, 32'h0);
		m.aim(2'h2, 16'h0002, 8'h05);
		chk("periph dest", {1'b0, 32'h00020502}, {1'b0, m.dest});
		rq(8'h25, 16'h0502, 1'b0, 32'h0);
		rp(RET, 1'b1, 2, 32'hA5C30F1E);
		rq(8'h25, 16'h0505, 1'b0, 32'h0);
		rp(RET, 1'b0, 0, 32'h0);
		$display("message test done");
	endtask
	task automatic t_status();
		ps(1'b1, 16'h070C, 32'h12345678, 1'b0, 32'h0);
		ps(1'b0, 16'h070C, 32'h0, 1'b0, 32'h12345678);
		ps(1'b0, 16'h050C, 32'h0, 1'b0, 32'hA5C30F1E);
		ps(1'b1, 16'h070D, 32'h0, 1'b1, 32'h0);
		ps(1'b0, 16'h100C, 32'h0, 1'b1, 32'h0);
		rq(8'hC1, 16'h0007, 1'b0, 32'h0);
		rp(RET, 1'b1, 4, 32'h12345678);
		$display("status test done");
	endtask
	initial begin
		{rst_n_i, ps_req_i, ps_wr_i, ps_resid_i, ps_wdata_i} = 51'h0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_msg();
		t_status();
		chk("send stalls", 33'h0, 33'(m.stalls));
		finish_test();
	end
	// The tests need under 250 cycles; the 10000-cycle limit allows forty times that.
	initial begin
		#100000;
		err_total++;
		finish_test();
	end
endmodule // tb_top
